// ==== rtl/tag_type_select_and_quit.sv ====
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tag_select_params.svh"

// Summary of operation
// - tag type is two ascii characters, high first
// - selected tag type kept in non-volatile store
// - each tag type is read-only or writable class
// - vicinity generic code only reads unique identifier
// - large fram tag uses eight-byte blocks
// - access key applied per four-block sector
// - default access key is all ones
// - key write changes reader copy only
// - reader access key kept in non-volatile store
// - wildcard code uses head's own default type
// - factory code is wildcard on every channel
// - proximity any, 1k and 4k tags accept four or seven byte identifiers
// - quit aborts channel command, echoes command code
module tag_type_select_and_quit (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       nv_rstn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [`TS_NUM_CHAN-1:0]    head_done,
  output tag_select_pkg::head_cmd_t       head_cmd,
  output logic [`TS_NUM_CHAN-1:0]         head_abort,
  output logic [`TS_NUM_CHAN-1:0]         head_busy,
  output logic [47:0]                     head_key
);

  typedef struct packed {
    tag_select_pkg::state_e_t st;
    logic [63:0]              frame;
    logic [31:0]              resp;
    logic [7:0]               reply_cnt;
    logic [`TS_NUM_CHAN-1:0]  busy;
    logic                     resp_valid;
    logic                     dropped;
    logic [31:0]              rdata;
    logic                     rd_ready;
    logic [`TS_NUM_CHAN-1:0]  abort;
    logic                     fwd;
  } regs_t;

  regs_t                      s_q;
  regs_t                      s_d;
  tag_select_pkg::store_req_t store_req;
  logic [15:0]                store_code;
  logic [47:0]                store_key;
  tag_select_pkg::tag_info_t  rd_info;

  // classifies a tag type code
  function automatic tag_select_pkg::tag_info_t classify(input logic [15:0] code);
    tag_select_pkg::tag_info_t i;
    i = '0;
    case (code)
      16'h3032, 16'h3430, 16'h3532, 16'h3733, 16'h3735, 16'h3830: begin
        i.valid = 1'b1;
      end
      16'h3033, 16'h3131, 16'h3132, 16'h3230, 16'h3231, 16'h3232, 16'h3233, 16'h3234,
      16'h3331, 16'h3333, 16'h3334, 16'h3335, 16'h3431, 16'h3432, 16'h3433, 16'h3530,
      16'h3732, 16'h3734, 16'h3736: begin
        i.valid    = 1'b1;
        i.writable = 1'b1;
      end
      `TS_CODE_WILDCARD: begin
        i.valid        = 1'b1;
        i.head_default = 1'b1;
      end
      default: begin
        i.valid = 1'b0;
      end
    endcase
    if (code == `TS_CODE_VICINITY) begin
      i.writable = 1'b0;
      i.uid_only = 1'b1;
    end
    i.block_8    = (code == `TS_CODE_FRAM_8B);
    i.block_16   = (code == `TS_CODE_PROX_ANY) || (code == `TS_CODE_PROX_UL) ||
                   (code == `TS_CODE_PROX_1K) || (code == `TS_CODE_PROX_4K);
    i.sector_key = (code == `TS_CODE_PROX_1K) || (code == `TS_CODE_PROX_4K);
    i.uid_4_or_7 = (code == `TS_CODE_PROX_ANY) || i.sector_key;
    return i;
  endfunction

  logic       apb_setup;
  logic       apb_access;
  logic       addr_hit;
  logic       is_info;
  logic [7:0] cmd_code;
  logic [2:0] cmd_chan;
  logic [1:0] chan_idx;
  logic       chan_ok;
  logic       wr_ok;

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign is_info    = (paddr >= `TS_ADDR_INFO_BASE) && (paddr <= `TS_ADDR_INFO_LAST) && (paddr[1:0] == 2'b00);
  assign addr_hit   = is_info || paddr == `TS_ADDR_CMD_LO || paddr == `TS_ADDR_CMD_HI ||
                      paddr == `TS_ADDR_CTRL || paddr == `TS_ADDR_RESP || paddr == `TS_ADDR_STATUS ||
                      paddr == `TS_ADDR_KEY_LO || paddr == `TS_ADDR_KEY_HI;
  assign pready     = apb_access && (pwrite || s_q.rd_ready);
  assign pslverr    = pready && !addr_hit;
  assign wr_ok      = apb_access && pwrite && addr_hit;
  assign prdata     = s_q.rdata;

  // quit reads only the channel and toggle bit of byte 1
  assign cmd_code = s_q.frame[7:0];
  assign cmd_chan = s_q.frame[8+`TS_CHAN_MSB:8+`TS_CHAN_LSB];
  assign chan_ok  = (cmd_chan != 3'd0) && (cmd_chan <= 3'(`TS_NUM_CHAN));
  assign chan_idx = 2'(cmd_chan - 3'd1);

  assign rd_info  = classify(store_code);

  tag_select_pkg::tag_info_t sel_info;
  logic                      sel_valid;

  assign sel_info  = classify({s_q.frame[23:16], s_q.frame[31:24]});
  assign sel_valid = sel_info.valid;

  // store port: tag code write from the engine, key low 32 and high 16 bits from the bus
  always_comb begin
    store_req           = '0;
    store_req.rd_idx    = paddr[3:2];
    store_req.code_idx  = chan_idx;
    store_req.key_data  = pwdata;
    if (s_q.st == tag_select_pkg::ST_EXEC && cmd_code == `TS_CMD_SELECT && chan_ok) begin
      store_req.code_we = sel_valid;
    end
    // only the reader's copy is written; no path leads to the tag
    store_req.key_we[0] = wr_ok && paddr == `TS_ADDR_KEY_LO && (&pstrb);
    store_req.key_we[1] = wr_ok && paddr == `TS_ADDR_KEY_HI && (&pstrb[1:0]);
    store_req.code_data = {s_q.frame[23:16], s_q.frame[31:24]};
  end

  tag_select_store u_store (
    .pclk    (pclk),
    .nv_rstn (nv_rstn),
    .req     (store_req),
    .rd_code (store_code),
    .key     (store_key)
  );

  logic [7:0] status_byte;

  always_comb begin
    s_d          = s_q;
    s_d.abort    = '0;
    s_d.fwd      = 1'b0;
    status_byte  = `TS_STATUS_OK;

    // bus read data: captured in the first access cycle, answered in the next
    if (!apb_access) begin
      s_d.rd_ready = 1'b0;
    end else if (!pwrite && !s_q.rd_ready) begin
      s_d.rd_ready = 1'b1;
      s_d.rdata    = '0;
      case (paddr)
        `TS_ADDR_CMD_LO: s_d.rdata = s_q.frame[31:0];
        `TS_ADDR_CMD_HI: s_d.rdata = s_q.frame[63:32];
        `TS_ADDR_RESP:   s_d.rdata = s_q.resp;
        `TS_ADDR_STATUS: begin
          s_d.rdata[`TS_NUM_CHAN-1:0]    = s_q.busy;
          s_d.rdata[`TS_STAT_RESP_BIT]   = s_q.resp_valid;
          s_d.rdata[`TS_STAT_ENGINE_BIT] = (s_q.st != tag_select_pkg::ST_IDLE);
          s_d.rdata[`TS_STAT_DROP_BIT]   = s_q.dropped;
        end
        `TS_ADDR_KEY_LO: s_d.rdata = store_key[31:0];
        `TS_ADDR_KEY_HI: s_d.rdata = {16'h0000, store_key[47:32]};
        default: begin
          if (is_info) begin
            s_d.rdata = {8'h00, rd_info, store_code};
          end
        end
      endcase
    end else begin
      s_d.rd_ready = s_q.rd_ready;
    end

    // frame loading is held off while the engine works on it
    if (wr_ok && s_q.st == tag_select_pkg::ST_IDLE) begin
      if (paddr == `TS_ADDR_CMD_LO) begin
        s_d.frame[31:0] = pwdata;
      end
      if (paddr == `TS_ADDR_CMD_HI) begin
        s_d.frame[63:32] = pwdata;
      end
    end

    // response and drop flags: write one to clear; busy and engine bits ignore writes
    if (wr_ok && paddr == `TS_ADDR_STATUS) begin
      if (pwdata[`TS_STAT_RESP_BIT]) begin
        s_d.resp_valid = 1'b0;
      end
      if (pwdata[`TS_STAT_DROP_BIT]) begin
        s_d.dropped = 1'b0;
      end
    end

    // completion from a head ends that channel's running command
    s_d.busy = s_q.busy & ~head_done;

    case (s_q.st)
      tag_select_pkg::ST_IDLE: begin
        if (wr_ok && paddr == `TS_ADDR_CTRL && pwdata[`TS_CTRL_GO_BIT]) begin
          s_d.st = tag_select_pkg::ST_EXEC;
        end
      end
      tag_select_pkg::ST_EXEC: begin
        s_d.st = tag_select_pkg::ST_RESP;
        if (!chan_ok) begin
          status_byte = `TS_STATUS_BAD_CHAN;
        end else if (cmd_code == `TS_CMD_QUIT) begin
          s_d.abort[chan_idx] = s_q.busy[chan_idx];
          s_d.busy[chan_idx]  = 1'b0;
        end else if (cmd_code == `TS_CMD_SELECT) begin
          if (!sel_valid) begin
            status_byte = `TS_STATUS_BAD_TYPE;
          end
        end else begin
          // any other command runs on the head; the head answers it
          s_d.fwd            = 1'b1;
          s_d.busy[chan_idx] = 1'b1;
          s_d.st             = tag_select_pkg::ST_IDLE;
        end
        if (s_d.st == tag_select_pkg::ST_RESP) begin
          s_d.reply_cnt = s_q.reply_cnt + 8'h01;
          s_d.resp      = {s_q.reply_cnt + 8'h01, status_byte,
                           4'h0, s_q.frame[8+`TS_CHAN_MSB:8], cmd_code};
        end
      end
      tag_select_pkg::ST_RESP: begin
        s_d.resp_valid = 1'b1;
        s_d.st         = tag_select_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = tag_select_pkg::ST_IDLE;
      end
    endcase

    // a submit while the engine works is dropped and flagged; set wins over clear
    if (wr_ok && paddr == `TS_ADDR_CTRL && pwdata[`TS_CTRL_GO_BIT] && s_q.st != tag_select_pkg::ST_IDLE) begin
      s_d.dropped = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q    <= '0;
      s_q.st <= tag_select_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign head_cmd.valid = s_q.fwd;
  assign head_cmd.chan  = 2'(s_q.frame[8+`TS_CHAN_MSB:8+`TS_CHAN_LSB] - 3'd1);
  assign head_cmd.frame = s_q.frame;
  assign head_abort     = s_q.abort;
  assign head_busy      = s_q.busy;
  assign head_key       = store_key;

endmodule

// ==== inc/tag_select_params.svh ====
`ifndef TAG_SELECT_PARAMS_SVH
`define TAG_SELECT_PARAMS_SVH

// apb register byte offsets
`define TS_ADDR_CMD_LO     8'h00
`define TS_ADDR_CMD_HI     8'h04
`define TS_ADDR_CTRL       8'h08
`define TS_ADDR_RESP       8'h0C
`define TS_ADDR_STATUS     8'h10
`define TS_ADDR_KEY_LO     8'h14
`define TS_ADDR_KEY_HI     8'h18
`define TS_ADDR_INFO_BASE  8'h20
`define TS_ADDR_INFO_LAST  8'h2C

// control and status fields
`define TS_CTRL_GO_BIT     0
`define TS_STAT_RESP_BIT   4
`define TS_STAT_ENGINE_BIT 5
`define TS_STAT_DROP_BIT   6

// frame geometry
`define TS_NUM_CHAN        4
`define TS_CHAN_LSB        1
`define TS_CHAN_MSB        3

// command codes
`define TS_CMD_QUIT        8'h02
`define TS_CMD_SELECT      8'h04

// response status codes
`define TS_STATUS_OK       8'h00
`define TS_STATUS_BAD_CHAN 8'h04
`define TS_STATUS_BAD_TYPE 8'h05

// factory values kept by the non-volatile store
`define TS_CODE_WILDCARD   16'h3939
`define TS_KEY_DEFAULT     48'hFFFF_FFFF_FFFF

// tag type codes, high ascii char in upper byte
`define TS_CODE_VICINITY   16'h3230
`define TS_CODE_FRAM_8B    16'h3333
`define TS_CODE_PROX_ANY   16'h3430
`define TS_CODE_PROX_UL    16'h3431
`define TS_CODE_PROX_1K    16'h3432
`define TS_CODE_PROX_4K    16'h3433

`endif

// ==== inc/tag_select_pkg.sv ====
package tag_select_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_RESP = 3'b100
  } state_e_t;

  // decoded properties of one tag type code
  typedef struct packed {
    logic valid;
    logic writable;
    logic uid_only;
    logic head_default;
    logic block_8;
    logic block_16;
    logic sector_key;
    logic uid_4_or_7;
  } tag_info_t;

  // command frame toward the read/write heads
  typedef struct packed {
    logic        valid;
    logic [1:0]  chan;
    logic [63:0] frame;
  } head_cmd_t;

  typedef struct packed {
    logic        code_we;
    logic [1:0]  code_idx;
    logic [15:0] code_data;
    logic [1:0]  key_we;
    logic [31:0] key_data;
    logic [1:0]  rd_idx;
  } store_req_t;

endpackage

// ==== rtl/tag_select_store.sv ====
`timescale 1ns/1ps
`include "tag_select_params.svh"

// non-volatile image: per channel tag code and reader key; only nv_rstn loads factory values
module tag_select_store (
  input  wire logic                      pclk,
  input  wire logic                      nv_rstn,
  input  wire tag_select_pkg::store_req_t req,
  output logic [15:0]                    rd_code,
  output logic [47:0]                    key
);

  logic [15:0] code_q [`TS_NUM_CHAN];

  genvar g;
  generate
    for (g = 0; g < `TS_NUM_CHAN; g++) begin : g_code
      always_ff @(posedge pclk or negedge nv_rstn) begin
        if (!nv_rstn) begin
          code_q[g] <= `TS_CODE_WILDCARD;
        end else if (req.code_we && req.code_idx == 2'(g)) begin
          code_q[g] <= req.code_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge nv_rstn) begin
    if (!nv_rstn) begin
      key     <= `TS_KEY_DEFAULT;
      rd_code <= `TS_CODE_WILDCARD;
    end else begin
      if (req.key_we[0]) begin
        key[31:0] <= req.key_data;
      end
      if (req.key_we[1]) begin
        key[47:32] <= req.key_data[15:0];
      end
      rd_code <= code_q[req.rd_idx];
    end
  end

endmodule

// ==== tb/tag_type_select_and_quit_asserts.sv ====
`timescale 1ns/1ps
`include "tag_select_params.svh"
module tag_type_select_and_quit_asserts (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      nv_rstn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [`TS_NUM_CHAN-1:0]   head_done,
  input wire tag_select_pkg::head_cmd_t head_cmd,
  input wire logic [`TS_NUM_CHAN-1:0]   head_abort,
  input wire logic [`TS_NUM_CHAN-1:0]   head_busy,
  input wire logic [47:0]               head_key
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic kw;
  assign kw = psel && penable && pwrite && (paddr == `TS_ADDR_KEY_LO || paddr == `TS_ADDR_KEY_HI);
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_wr_fast; psel && penable && pwrite && !$past(penable) |-> pready; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write not answered at once");
  property p_rd_wait; psel && penable && !pwrite && !$past(penable) |-> !pready ##1 pready; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_key_src; $changed(head_key) |-> $past(kw) || $past(kw, 2); endproperty
  a_key_src: assert property (p_key_src) else $error("key changed without key write");
  property p_abort; head_abort != 0 |-> (head_abort & (head_busy | ~$past(head_busy))) == 0; endproperty
  a_abort: assert property (p_abort) else $error("abort on idle channel or busy kept");
  property p_abort_pulse; head_abort != 0 |=> head_abort == 0; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle");
  property p_cmd_busy; head_cmd.valid |-> head_busy[head_cmd.chan]; endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("forwarded command not busy");
  property p_busy_rise; (head_busy & ~$past(head_busy)) != 0 |-> head_cmd.valid; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy set without command");
  property p_done_clr; head_done != 0 |=> (head_busy & $past(head_done)) == 0; endproperty
  a_done_clr: assert property (p_done_clr) else $error("busy kept after done");
  c_abort: cover property (head_abort != 0);
  c_cmd: cover property (head_cmd.valid);
  c_err: cover property (pslverr);
endmodule
bind tag_type_select_and_quit tag_type_select_and_quit_asserts u_chk (.pclk, .presetn, .nv_rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .head_done, .head_cmd, .head_abort,
  .head_busy, .head_key);

// ==== tb/head_model.sv ====
`timescale 1ns/1ps
module head_model (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      hold,
  input  wire tag_select_pkg::head_cmd_t head_cmd,
  input  wire logic [3:0]                head_abort,
  output logic [3:0]                     head_done
);
  logic [3:0] pend_q;
  logic [2:0] wait_q;
  // hold stalls completion so a quit can hit a running command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q    <= 4'h0;
      wait_q    <= 3'h0;
      head_done <= 4'h0;
    end else begin
      head_done <= 4'h0;
      if (head_cmd.valid) begin
        pend_q[head_cmd.chan] <= 1'b1;
        wait_q                <= 3'h4;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end else if (!hold && (pend_q & ~head_abort) != 4'h0) begin
        head_done <= pend_q & ~head_abort;
        pend_q    <= 4'h0;
      end else begin
        pend_q <= pend_q & ~head_abort;
      end
    end
  end
endmodule

// ==== tb/tag_type_select_and_quit_bench.sv ====
`timescale 1ns/1ps
`include "tag_select_params.svh"
module tag_type_select_and_quit_bench;
  logic pclk = 0, presetn = 0, nv_rstn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0, pslverr, pready, err;
  logic [7:0] paddr = 0, rc = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hF, head_done, head_abort, head_busy, ab_seen = 0;
  logic [47:0] head_key;
  logic [63:0] fwd_frame = 0;
  logic [1:0]  fwd_chan = 0;
  tag_select_pkg::head_cmd_t head_cmd;
  int err_count = 0, num_checks = 0, cyc = 0;
  logic [15:0] codes [5] = '{16'h3230, 16'h3333, 16'h3432, 16'h3032, 16'h3939};
  logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] val [5] = '{8'hA0, 8'hC8, 8'hC7, 8'h80, 8'h90};
  tag_type_select_and_quit dut (.pclk, .presetn, .nv_rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .head_done, .head_cmd, .head_abort, .head_busy, .head_key);
  head_model u_head (.pclk, .presetn, .hold, .head_cmd, .head_abort, .head_done);
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    ab_seen <= presetn ? (ab_seen | head_abort) : 4'h0;
    if (head_cmd.valid === 1'b1) begin
      fwd_frame <= head_cmd.frame;
      fwd_chan  <= head_cmd.chan;
    end
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(string n, logic [47:0] got, logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cmd(logic [7:0] c, logic [7:0] b1, logic [15:0] tt, logic [31:0] hi);
    apb(1, `TS_ADDR_CMD_LO, {tt[7:0], tt[15:8], b1, c}, 4'hF);
    apb(1, `TS_ADDR_CMD_HI, hi, 4'hF);
    apb(1, `TS_ADDR_CTRL, 32'h1, 4'hF);
  endtask
  task automatic resp(logic [7:0] c, logic [7:0] b1, logic [7:0] st);
    int n;
    n = 0;
    do begin apb(0, `TS_ADDR_STATUS, 0, 4'hF); n++; end while (rd[4] !== 1'b1 && n < 50);
    chk("rvalid", rd[4], 1'b1);
    rc++;
    apb(0, `TS_ADDR_RESP, 0, 4'hF);
    chk("resp", rd, {rc, st, b1 & 8'h0F, c});
    apb(1, `TS_ADDR_STATUS, 32'h10, 4'hF);
  endtask
  task automatic t_factory();
    for (int ch = 0; ch < 4; ch++) begin
      apb(0, `TS_ADDR_INFO_BASE + 8'(4 * ch), 0, 4'hF);
      chk("code", rd[15:0], `TS_CODE_WILDCARD);
      chk("hdef", rd[20], 1'b1);
    end
    apb(0, `TS_ADDR_KEY_LO, 0, 4'hF);
    chk("keylo", rd, 32'hFFFF_FFFF);
    chk("key", head_key, `TS_KEY_DEFAULT);
    $display("factory done");
  endtask
  task automatic t_select();
    for (int i = 0; i < 5; i++) begin
      cmd(`TS_CMD_SELECT, {4'hA, 3'(i % 4 + 1), 1'(i)}, codes[i], 32'h0);
      resp(`TS_CMD_SELECT, {4'hA, 3'(i % 4 + 1), 1'(i)}, `TS_STATUS_OK);
      apb(0, `TS_ADDR_INFO_BASE + 8'(4 * (i % 4)), 0, 4'hF);
      chk("code", rd[15:0], codes[i]);
      chk("info", rd[23:16] & msk[i], val[i]);
    end
    cmd(`TS_CMD_SELECT, 8'h0A, 16'h3432, 32'h0);
    resp(`TS_CMD_SELECT, 8'h0A, `TS_STATUS_BAD_CHAN);
    cmd(`TS_CMD_SELECT, 8'h02, 16'h3941, 32'h0);
    resp(`TS_CMD_SELECT, 8'h02, `TS_STATUS_BAD_TYPE);
    apb(0, `TS_ADDR_INFO_BASE, 0, 4'hF);
    chk("kept", rd[15:0], `TS_CODE_WILDCARD);
    $display("select done");
  endtask
  task automatic t_quit();
    int n;
    hold <= 1;
    cmd(8'h01, 8'h05, 16'h0, 32'h0006_0010);
    apb(0, `TS_ADDR_STATUS, 0, 4'hF);
    chk("busy", rd[3:0], 4'b0010);
    chk("busy", head_busy, 4'b0010);
    chk("fwdlo", fwd_frame[31:0], 32'h0000_0501);
    chk("fwdhi", fwd_frame[63:32], 32'h0006_0010);
    chk("fwdch", fwd_chan, 2'd1);
    cmd(`TS_CMD_QUIT, 8'hF5, 16'h5A5A, 32'hDEAD_BEEF);
    resp(`TS_CMD_QUIT, 8'hF5, `TS_STATUS_OK);
    chk("abort", ab_seen, 4'b0010);
    chk("idle", head_busy, 4'h0);
    hold <= 0;
    cmd(8'h01, 8'h06, 16'h0, 32'h0008_0000);
    n = 0;
    do begin apb(0, `TS_ADDR_STATUS, 0, 4'hF); n++; end while (rd[2] !== 1'b0 && n < 50);
    chk("stat", rd[6:0], 7'h0);
    chk("fwdhi", fwd_frame[63:32], 32'h0008_0000);
    chk("fwdch", fwd_chan, 2'd2);
    $display("quit done");
  endtask
  // second go lands back to back while the engine still answers the first
  task automatic t_drop();
    apb(1, `TS_ADDR_CMD_LO, {16'h3939, 8'h03, `TS_CMD_SELECT}, 4'hF);
    @(posedge pclk);
    psel <= 1; pwrite <= 1; paddr <= `TS_ADDR_CTRL; pwdata <= 32'h1; pstrb <= 4'hF;
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      penable <= 0;
    end
    psel <= 0;
    resp(`TS_CMD_SELECT, 8'h03, `TS_STATUS_OK);
    apb(0, `TS_ADDR_STATUS, 0, 4'hF);
    chk("drop", rd[6:4], 3'b100);
    apb(1, `TS_ADDR_STATUS, 32'h40, 4'hF);
    apb(0, `TS_ADDR_STATUS, 0, 4'hF);
    chk("drop", rd[6:4], 3'b000);
    $display("drop done");
  endtask
  task automatic t_key();
    apb(1, `TS_ADDR_KEY_LO, 32'h1122_3344, 4'hF);
    apb(1, `TS_ADDR_KEY_HI, 32'h0000_5566, 4'h3);
    apb(1, `TS_ADDR_KEY_LO, 32'h0, 4'h7);
    chk("key", head_key, 48'h5566_1122_3344);
    apb(0, `TS_ADDR_KEY_HI, 0, 4'hF);
    chk("keyhi", rd, 32'h0000_5566);
    apb(0, 8'h40, 0, 4'hF);
    chk("slverr", err, 1'b1);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `TS_ADDR_INFO_BASE + 8'h08, 0, 4'hF);
    chk("nvcode", rd[15:0], 16'h3432);
    chk("nvkey", head_key, 48'h5566_1122_3344);
    $display("key done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    nv_rstn <= 1;
    t_factory();
    t_select();
    t_quit();
    t_drop();
    t_key();
    final_report();
  end
endmodule
